// *** ebhr_defs.vh ***
// Shared constants for the external bus hold and ready block
`ifndef EBHR_DEFS_VH
`define EBHR_DEFS_VH

// =====================================================================
// Address map and field positions
`define EBHR_AW 24
`define EBHR_P4_DATA_ADDR 24'h00000a
`define EBHR_P4_DIR_ADDR 24'h00000c
`define EBHR_CM6_BIT 6
`define EBHR_SBY_BIT 0

// =====================================================================
// Timing: hold float and release delay in internal clock cycles
`define EBHR_HOLD_DELAY 1
// Clock output divider half period in system clocks
`define EBHR_PHI_HALF 2

// =====================================================================
// Reset values
`define EBHR_RST_BUS_GRANT_ACK_N 1'b1
`define EBHR_RST_STROBE 1'b1

`endif

// *** ebhr_phase_gen.v ***
// Internal clock phase generator with ready stall and free running clock output
`timescale 1ns/10ps
`default_nettype none
`include "ebhr_defs.vh"

module ebhr_phase_gen #(
    parameter HALF = `EBHR_PHI_HALF
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Control
    input wire rdy_n_i,
    // Phases
    output reg phi_o,
    output reg phi_fall_o,
    output reg phi1_o
);
    reg [7:0] cnt_reg;
    reg [7:0] cnt1_reg;

    // =================================================================
    // Internal clock stops low while ready is asserted
    always @(posedge clock_i) begin
        if (srst_i) begin
            cnt_reg <= 8'h00;
            phi_o <= 1'b0;
            phi_fall_o <= 1'b0;
        end else begin
            phi_fall_o <= 1'b0;
            if (phi_o == 1'b0 && !rdy_n_i) begin
                cnt_reg <= 8'h00;
            end else if (cnt_reg == HALF[7:0] - 8'h01) begin
                cnt_reg <= 8'h00;
                phi_o <= ~phi_o;
                phi_fall_o <= phi_o;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    // =================================================================
    // Clock output ignores ready
    always @(posedge clock_i) begin
        if (srst_i) begin
            cnt1_reg <= 8'h00;
            phi1_o <= 1'b0;
        end else if (cnt1_reg == HALF[7:0] - 8'h01) begin
            cnt1_reg <= 8'h00;
            phi1_o <= ~phi1_o;
        end else begin
            cnt1_reg <= cnt1_reg + 8'h01;
        end
    end
endmodule

`default_nettype wire

// *** ebhr_debug_out.v ***
// Evaluation mode debug status outputs
`timescale 1ns/10ps
`default_nettype none

module ebhr_debug_out (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // CPU status
    input wire eval_mode_i,
    input wire flag_m_i,
    input wire flag_x_i,
    input wire using_x_i,
    input wire queue_clear_i,
    input wire data_buf_access_i,
    input wire opcode_fetch_i,
    input wire queue_read_i,
    // Debug pins
    output reg width_flag_out_o,
    output reg queue_flush_out_o,
    output reg valid_data_addr_out_o,
    output reg valid_prog_addr_out_o
);
    // =================================================================
    // Status pins only exist in evaluation mode
    always @(posedge clock_i) begin
        if (srst_i) begin
            width_flag_out_o <= 1'b0;
            queue_flush_out_o <= 1'b0;
            valid_data_addr_out_o <= 1'b0;
            valid_prog_addr_out_o <= 1'b0;
        end else begin
            width_flag_out_o <= eval_mode_i & (using_x_i ? flag_x_i : flag_m_i);
            queue_flush_out_o <= eval_mode_i & queue_clear_i;
            valid_data_addr_out_o <= eval_mode_i & (data_buf_access_i | opcode_fetch_i);
            valid_prog_addr_out_o <= eval_mode_i & queue_read_i;
        end
    end
endmodule

`default_nettype wire

// *** ebhr_bus_ctrl.v ***
// External bus control: hold, ready, strobes, mode dependent pin functions
`timescale 1ns/10ps
`default_nettype none
`include "ebhr_defs.vh"

// How it works
// - Hold request sampled only at internal clock falling edge with bus idle.
// - Accepting hold drives hold acknowledge low.
// - Bus pins float one internal cycle after acknowledge falls, stay floating.
// - Acknowledge rises on exit; pins driven again one internal cycle later.
// - Ready low stops internal clock in its low phase.
// - Clock output keeps toggling while internal clock is stalled.
// - Processor mode with disable bit and p42_dir_i set: clock pin shows port latch value.
// - Disable bit clear strobes all accesses; set strobes external ones only outside evaluation mode.
// - After wait/stop outside evaluation mode, strobe is low if disable bit and standby select are both set, high otherwise.
// - Evaluation mode: middle byte carries address, then odd data.
// - Evaluation, width pin low: upper byte address, then even data.
// - Evaluation, width pin high: upper byte address, then both data bytes.
// - Internal reads ignore external data pins.
// - Evaluation port 4 accesses use 16-bit width and no-wait timing.
// - Evaluation mode always outputs clock on clock pin.
// - Evaluation mode port 4 pins become debug outputs and debug input.
// - Width flag shows data length flag, or index flag when in use.
// - Queue flush high when instruction queue is cleared.
// - Valid data address high for data buffer access or opcode read.
// - Valid program address high while reading instruction queue.
// - Mode pin at supply: processor mode; at twice supply: evaluation only.
// - Strobe low during strobed read or write terms and in the standby low case above, high otherwise.
// - Direction output high for reads, low for writes.
// - Upper byte enable low for odd byte access.
module ebhr_bus_ctrl #(
    parameter AW = `EBHR_AW,
    parameter HALF = `EBHR_PHI_HALF
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Mode straps
    input wire mode_select_pin_i,
    input wire byte_wide_i,
    // Configuration
    input wire strobe_clock_out_disable_i,
    input wire standby_sel_i,
    input wire wait_bit_i,
    input wire p42_latch_i,
    input wire p42_dir_i,
    // Bus partner
    input wire hold_req_n_i,
    input wire rdy_n_i,
    input wire [15:0] data_pin_i,
    // CPU request
    input wire req_i,
    input wire req_write_i,
    input wire req_internal_i,
    input wire [AW-1:0] req_addr_i,
    input wire [15:0] req_wdata_i,
    input wire [15:0] int_rdata_i,
    input wire wait_stop_instr_i,
    // CPU status for debug pins
    input wire flag_m_i,
    input wire flag_x_i,
    input wire using_x_i,
    input wire queue_clear_i,
    input wire data_buf_access_i,
    input wire opcode_fetch_i,
    input wire queue_read_i,
    input wire debug_ctrl_in_i,
    // CPU answer
    output reg done_o,
    output reg [15:0] rdata_o,
    output reg bus16_o,
    output reg eval_mode_o,
    output reg debug_ctrl_o,
    // Bus pins
    output reg [7:0] addr_low_o,
    output reg [7:0] mid_o,
    output reg [7:0] mid_oe_o,
    output reg [7:0] upper_o,
    output reg [7:0] upper_oe_o,
    output reg addr_low_oe_o,
    output reg strobe_n_o,
    output reg rw_o,
    output reg rw_oe_o,
    output reg upper_byte_enable_n_o,
    output reg ube_oe_o,
    output reg ale_o,
    output reg bus_grant_ack_n_o,
    output reg phi1_pin_o,
    output reg phi_o,
    // Debug pins
    output wire width_flag_out_o,
    output wire queue_flush_out_o,
    output wire valid_data_addr_out_o,
    output wire valid_prog_addr_out_o
);
    // =================================================================
    // Bus states
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_DATA = 3'd2;
    localparam S_WAIT = 3'd3;
    localparam S_HOLD = 3'd4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg float_reg;
    reg float_pend_reg;
    reg wait_ext_reg;
    reg req_write_reg;
    reg req_internal_reg;
    reg [AW-1:0] addr_reg;
    reg [15:0] wdata_reg;
    reg eval_reg;
    reg p4_reg;
    reg standby_reg;
    wire phi_int;
    wire phi_fall;
    wire phi1_raw;
    wire start_cycle;
    wire end_cycle;

    // =================================================================
    // Decode helpers
    // Word compare on the upper address bits covers both bytes of a location
    function is_p4;
        input [AW-1:0] a;
        reg [AW-1:0] data_loc;
        reg [AW-1:0] dir_loc;
        begin
            data_loc = `EBHR_P4_DATA_ADDR;
            dir_loc = `EBHR_P4_DIR_ADDR;
            is_p4 = (a[AW-1:1] == data_loc[AW-1:1]) || (a[AW-1:1] == dir_loc[AW-1:1]);
        end
    endfunction

    function in_data;
        input [2:0] s;
        begin
            in_data = (s == S_DATA) || (s == S_WAIT);
        end
    endfunction

    ebhr_phase_gen #(
        .HALF(HALF)
    ) u_phase (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .rdy_n_i(rdy_n_i),
        .phi_o(phi_int),
        .phi_fall_o(phi_fall),
        .phi1_o(phi1_raw)
    );

    ebhr_debug_out u_debug (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .eval_mode_i(eval_reg),
        .flag_m_i(flag_m_i),
        .flag_x_i(flag_x_i),
        .using_x_i(using_x_i),
        .queue_clear_i(queue_clear_i),
        .data_buf_access_i(data_buf_access_i),
        .opcode_fetch_i(opcode_fetch_i),
        .queue_read_i(queue_read_i),
        .width_flag_out_o(width_flag_out_o),
        .queue_flush_out_o(queue_flush_out_o),
        .valid_data_addr_out_o(valid_data_addr_out_o),
        .valid_prog_addr_out_o(valid_prog_addr_out_o)
    );

    // =================================================================
    // Mode strap caught while reset is held
    always @(posedge clock_i) begin
        if (srst_i) begin
            eval_reg <= mode_select_pin_i;
        end
    end

    // =================================================================
    // Bus sequencer, advances only on internal clock falling edges
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (!hold_req_n_i) begin
                    state_next = S_HOLD;
                end else if (req_i) begin
                    state_next = S_ADDR;
                end
            end
            S_ADDR: begin
                state_next = S_DATA;
            end
            S_DATA: begin
                state_next = wait_ext_reg ? S_WAIT : S_IDLE;
            end
            S_WAIT: begin
                state_next = S_IDLE;
            end
            S_HOLD: begin
                if (hold_req_n_i) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // Cycle start and end, both taken on an internal clock falling edge
    assign start_cycle = (state_reg == S_IDLE) && (state_next == S_ADDR);
    assign end_cycle = (state_next == S_IDLE) && in_data(state_reg);

    always @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= S_IDLE;
            bus_grant_ack_n_o <= `EBHR_RST_BUS_GRANT_ACK_N;
            float_reg <= 1'b0;
            float_pend_reg <= 1'b0;
            wait_ext_reg <= 1'b0;
            req_write_reg <= 1'b0;
            req_internal_reg <= 1'b0;
            addr_reg <= {AW{1'b0}};
            wdata_reg <= 16'h0000;
            p4_reg <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            standby_reg <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (wait_stop_instr_i) begin
                standby_reg <= 1'b1;
            end else if (req_i) begin
                standby_reg <= 1'b0;
            end
            if (phi_fall) begin
                state_reg <= state_next;
                // Float follows acknowledge by one internal cycle
                float_pend_reg <= (state_next == S_HOLD);
                float_reg <= float_pend_reg;
                bus_grant_ack_n_o <= (state_next != S_HOLD);
                if (start_cycle) begin
                    req_write_reg <= req_write_i;
                    req_internal_reg <= req_internal_i;
                    addr_reg <= req_addr_i;
                    wdata_reg <= req_wdata_i;
                    p4_reg <= eval_reg && is_p4(req_addr_i);
                    // Port 4 in evaluation mode runs internal timing
                    wait_ext_reg <= !req_internal_i && !wait_bit_i &&
                                    !(eval_reg && is_p4(req_addr_i));
                end
                if (end_cycle) begin
                    done_o <= 1'b1;
                    if (req_internal_reg) begin
                        rdata_o <= int_rdata_i;
                    end else if (bus16_o) begin
                        rdata_o <= data_pin_i;
                    end else begin
                        rdata_o <= {8'h00, data_pin_i[7:0]};
                    end
                end
            end
        end
    end

    // =================================================================
    // Pin drive, registered from sequencer state
    always @(posedge clock_i) begin
        if (srst_i) begin
            strobe_n_o <= `EBHR_RST_STROBE;
            ale_o <= 1'b0;
            rw_o <= 1'b1;
            upper_byte_enable_n_o <= 1'b1;
            addr_low_o <= 8'h00;
            mid_o <= 8'h00;
            upper_o <= 8'h00;
            mid_oe_o <= 8'h00;
            upper_oe_o <= 8'h00;
            addr_low_oe_o <= 1'b0;
            rw_oe_o <= 1'b0;
            ube_oe_o <= 1'b0;
            bus16_o <= 1'b0;
            phi1_pin_o <= 1'b0;
            phi_o <= 1'b0;
            eval_mode_o <= 1'b0;
            debug_ctrl_o <= 1'b0;
        end else begin
            eval_mode_o <= eval_reg;
            debug_ctrl_o <= eval_reg & debug_ctrl_in_i;
            phi_o <= phi_int;
            // Internal locations, and port 4 locations in evaluation mode, always run 16 bits wide
            if (req_internal_reg || p4_reg) begin
                bus16_o <= 1'b1;
            end else begin
                bus16_o <= !byte_wide_i;
            end
            // Clock pin
            if (eval_reg) begin
                phi1_pin_o <= phi1_raw;
            end else if (strobe_clock_out_disable_i && p42_dir_i) begin
                phi1_pin_o <= p42_latch_i;
            end else begin
                phi1_pin_o <= phi1_raw;
            end
            // Strobe
            if (in_data(state_reg)) begin
                strobe_n_o <= req_internal_reg && strobe_clock_out_disable_i && !eval_reg;
            end else if (standby_reg && !eval_reg) begin
                strobe_n_o <= !(strobe_clock_out_disable_i && standby_sel_i);
            end else begin
                strobe_n_o <= 1'b1;
            end
            // Latch strobe high during address term; partner latch tracks it
            ale_o <= (state_reg == S_ADDR);
            rw_o <= !(req_write_reg && state_reg != S_IDLE && state_reg != S_HOLD);
            upper_byte_enable_n_o <= !(addr_reg[0] || (bus16_o && !req_internal_reg));
            addr_low_o <= addr_reg[7:0];
            addr_low_oe_o <= !float_reg;
            rw_oe_o <= !float_reg;
            ube_oe_o <= !float_reg;
            if (in_data(state_reg)) begin
                // Data term: middle byte odd data, upper byte even or both
                mid_o <= wdata_reg[15:8];
                upper_o <= (bus16_o || !byte_wide_i) ? wdata_reg[7:0] :
                           (addr_reg[0] ? wdata_reg[15:8] : wdata_reg[7:0]);
                // Evaluation mode keeps odd data on the middle byte at any width
                mid_oe_o <= (!float_reg && req_write_reg && (bus16_o || !byte_wide_i || eval_reg)) ?
                            8'hff : 8'h00;
                upper_oe_o <= (!float_reg && req_write_reg) ? 8'hff : 8'h00;
            end else begin
                mid_o <= addr_reg[15:8];
                upper_o <= addr_reg[AW-1:16];
                mid_oe_o <= float_reg ? 8'h00 : 8'hff;
                upper_oe_o <= float_reg ? 8'h00 : 8'hff;
            end
        end
    end
endmodule

`default_nettype wire

// *** ebhr_bus_ctrl_assertions.sv ***
// Port checks for the external bus hold and ready block
`timescale 1ns/10ps
`default_nettype none
module ebhr_bus_ctrl_assertions #(
    parameter AW = 24
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Inputs
    input wire logic hold_req_n_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_internal_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic strobe_clock_out_disable_i,
    input wire logic p42_latch_i,
    // Outputs
    input wire logic eval_mode_o,
    input wire logic strobe_n_o,
    input wire logic rw_o,
    input wire logic rw_oe_o,
    input wire logic ube_oe_o,
    input wire logic upper_byte_enable_n_o,
    input wire logic bus_grant_ack_n_o,
    input wire logic phi1_pin_o,
    input wire logic width_flag_out_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // ==========================================
    // Clock pin activity
    // Counter, not a long repetition, keeps the tools fast
    logic [3:0] still_reg;
    logic last_reg;
    always @(posedge clock_i) begin
        last_reg <= phi1_pin_o;
        if (srst_i || (!eval_mode_o && strobe_clock_out_disable_i) || phi1_pin_o != last_reg)
            still_reg <= 4'h0;
        else if (still_reg != 4'hf)
            still_reg <= still_reg + 4'h1;
    end
    // ==========================================
    // Properties
    hold_accept_a: assert property ($fell(bus_grant_ack_n_o) |-> !$past(hold_req_n_i) && strobe_n_o)
        else $error("hold granted without request");
    pin_float_a: assert property ($fell(bus_grant_ack_n_o) |-> ##[1:12] !(rw_oe_o || ube_oe_o))
        else $error("pins not floated in hold");
    hold_quiet_a: assert property (!bus_grant_ack_n_o |-> strobe_n_o)
        else $error("bus cycle during hold");
    hold_exit_a: assert property ($rose(bus_grant_ack_n_o) && !$past(srst_i) |->
        $past(hold_req_n_i) ##[1:12] (rw_oe_o && ube_oe_o))
        else $error("bad hold release");
    rw_level_a: assert property (req_i && $fell(strobe_n_o) |-> rw_o == !req_write_i)
        else $error("direction wrong");
    odd_byte_a: assert property (req_i && req_addr_i[0] && $fell(strobe_n_o) |-> !upper_byte_enable_n_o)
        else $error("upper byte enable wrong");
    int_strobe_a: assert property (req_i && req_internal_i && strobe_clock_out_disable_i && !eval_mode_o
        |-> !$fell(strobe_n_o))
        else $error("strobe on internal access");
    latch_out_a: assert property (!eval_mode_o && strobe_clock_out_disable_i && $stable(strobe_clock_out_disable_i)
        && $stable(p42_latch_i) && !$past(srst_i) |-> phi1_pin_o == p42_latch_i)
        else $error("clock pin not latch value");
    clock_run_a: assert property (still_reg < 4'h8)
        else $error("clock pin stopped");
    debug_off_a: assert property (!eval_mode_o && !$past(srst_i) |-> !width_flag_out_o)
        else $error("debug pin active outside evaluation");
endmodule
`default_nettype wire

// *** ebhr_ext_mem.sv ***
// External memory and hold master model
`timescale 1ns/10ps
`default_nettype none
module ebhr_ext_mem (
    // Clock
    input wire logic clock_i,
    // Device pins
    input wire logic [7:0] addr_low_i,
    input wire logic [7:0] mid_i,
    input wire logic [7:0] upper_i,
    input wire logic ale_i,
    input wire logic strobe_n_i,
    input wire logic rw_i,
    // Commands
    input wire logic hold_cmd_i,
    input wire logic slow_cmd_i,
    // Answers
    output logic [15:0] data_pin_o,
    output logic hold_req_n_o,
    output logic rdy_n_o
);
    logic [23:0] lat_reg = 24'h0;
    logic [3:0] stall_reg = 4'h0;
    initial begin
        data_pin_o = 16'h0;
        hold_req_n_o = 1'b1;
        rdy_n_o = 1'b1;
    end
    // ==========================================
    // Latch, data and ready
    always @(posedge clock_i) begin
        if (ale_i)
            lat_reg <= {upper_i, mid_i, addr_low_i};
        // Inverted pattern off the read term, so stale data never looks right
        if (!strobe_n_i && rw_i)
            data_pin_o <= {lat_reg[7:0] ^ 8'h3c, lat_reg[15:8]};
        else
            data_pin_o <= ~data_pin_o;
        hold_req_n_o <= !hold_cmd_i;
        // Ready goes low from the address term on; from the strobe alone it lands after the data term
        stall_reg <= (ale_i || !strobe_n_i) ? (stall_reg == 4'hf ? stall_reg : stall_reg + 4'h1) : 4'h0;
        rdy_n_o <= !(slow_cmd_i && (ale_i || !strobe_n_i) && stall_reg != 4'hf);
    end
endmodule
`default_nettype wire

// *** test_external_bus_hold_ready_eval.sv ***
// Testbench for the external bus hold and ready block
`timescale 1ns/10ps
`default_nettype none
`include "ebhr_defs.vh"
module test_external_bus_hold_ready_eval;
    // ==========================================
    // Signals
    logic clock_i = 0, srst_i = 1, mode_select_pin_i = 0, byte_wide_i = 0, standby_sel_i = 0;
    logic strobe_clock_out_disable_i = 0, wait_bit_i = 1, p42_latch_i = 0, p42_dir_i = 1;
    logic req_i = 0, req_write_i = 0, req_internal_i = 0, wait_stop_instr_i = 0, hold_cmd = 0, slow_cmd = 0;
    logic flag_m_i = 0, flag_x_i = 0, using_x_i = 0, queue_clear_i = 0, data_buf_access_i = 0;
    logic opcode_fetch_i = 0, queue_read_i = 0, debug_ctrl_in_i = 0, saw_low, b16;
    logic [23:0] req_addr_i = 0;
    logic [15:0] req_wdata_i = 0, int_rdata_i = 0, data_pin_i, rdata_o;
    logic hold_req_n_i, rdy_n_i, done_o, bus16_o, eval_mode_o, debug_ctrl_o, addr_low_oe_o, strobe_n_o, rw_o;
    logic rw_oe_o, upper_byte_enable_n_o, ube_oe_o, ale_o, bus_grant_ack_n_o, phi1_pin_o, phi_o;
    logic width_flag_out_o, queue_flush_out_o, valid_data_addr_out_o, valid_prog_addr_out_o;
    logic [7:0] addr_low_o, mid_o, mid_oe_o, upper_o, upper_oe_o, dbg;
    int miscompares = 0, samples_checked = 0, lat, i;
    wire [4:0] dbg_seen = {width_flag_out_o, queue_flush_out_o, valid_data_addr_out_o, valid_prog_addr_out_o,
        debug_ctrl_o};
    ebhr_bus_ctrl i_dut (.*);
    ebhr_ext_mem i_mem (.clock_i(clock_i), .addr_low_i(addr_low_o), .mid_i(mid_o), .upper_i(upper_o),
        .ale_i(ale_o), .strobe_n_i(strobe_n_o), .rw_i(rw_o), .hold_cmd_i(hold_cmd), .slow_cmd_i(slow_cmd),
        .data_pin_o(data_pin_i), .hold_req_n_o(hold_req_n_i), .rdy_n_o(rdy_n_i));
    always #2.5 clock_i = ~clock_i;
    // ==========================================
    // Helpers
    function automatic logic [15:0] exp_rd(input logic [23:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8]};
    endfunction
    function automatic logic [4:0] exp_dbg(input logic [7:0] d);
        return {d[5] ? d[6] : d[7], d[4], d[3] | d[2], d[1], d[0]};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic bound(input int n);
        if (n >= 200) begin
            check(1'b0, 1'b1);
            stop_test;
        end
    endtask
    task automatic reset_to(input logic m);
        srst_i = 1'b1;
        mode_select_pin_i = m;
        tick(2);
        srst_i = 1'b0;
        check({strobe_n_o, bus_grant_ack_n_o}, 2'h3);
        tick(1);
        $display("reset test done");
    endtask
    task automatic wait_ack(input logic lvl);
        int n;
        n = 0;
        while (bus_grant_ack_n_o !== lvl && n < 200) begin
            tick(1);
            n++;
        end
        bound(n);
    endtask
    task automatic access(input logic wr, input logic intl, input logic [23:0] a, input logic [15:0] wd);
        logic got_a;
        {req_write_i, req_internal_i, req_addr_i, req_wdata_i} = {wr, intl, a, wd};
        int_rdata_i = 16'($urandom);
        req_i = 1'b1;
        {saw_low, got_a} = 2'h0;
        lat = 0;
        while (done_o !== 1'b1 && lat < 200) begin
            tick(1);
            lat++;
            saw_low |= (strobe_n_o === 1'b0);
            // Data only counts once the address phase has been seen
            if (ale_o === 1'b1 && !intl) got_a = 1'b1;
            if (ale_o === 1'b1 && !intl) check({upper_o, mid_o, addr_low_o}, a);
            if (strobe_n_o === 1'b0 && got_a && wr && !byte_wide_i) check({mid_o, upper_o}, wd);
        end
        bound(lat);
        b16 = bus16_o;
        req_i = 1'b0;
        if (!wr && !a[0] && (intl || !byte_wide_i)) check(rdata_o, intl ? int_rdata_i : exp_rd(a));
        if (!eval_mode_o) check(saw_low, !(intl && strobe_clock_out_disable_i));
        tick(1);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(22611));
        reset_to(1'b0);
        check(eval_mode_o, 1'b0);
        access(1'b0, 1'b0, 24'h012346, 16'h0000);
        check(lat < 8 * `EBHR_PHI_HALF, 1'b1);
        slow_cmd = 1'b1;
        access(1'b0, 1'b0, 24'h034566, 16'h0000);
        check(lat >= 8 * `EBHR_PHI_HALF, 1'b1);
        slow_cmd = 1'b0;
        $display("ready test done");
        for (i = 0; i < 24; i++) begin
            strobe_clock_out_disable_i = 1'($urandom);
            byte_wide_i = 1'($urandom);
            flag_m_i = 1'($urandom);
            access(1'($urandom), 1'($urandom), 24'($urandom) | 24'h000100, 16'($urandom));
        end
        $display("random test done");
        {strobe_clock_out_disable_i, byte_wide_i, hold_cmd} = 3'h1;
        wait_ack(1'b0);
        tick(12);
        check({rw_oe_o, ube_oe_o, addr_low_oe_o, mid_oe_o, upper_oe_o}, 19'h0);
        hold_cmd = 1'b0;
        wait_ack(1'b1);
        tick(12);
        check({rw_oe_o, ube_oe_o, addr_low_oe_o}, 3'h7);
        $display("hold test done");
        for (i = 0; i < 4; i++) begin
            {strobe_clock_out_disable_i, standby_sel_i, p42_latch_i} = {i[1:0], i[0]};
            wait_stop_instr_i = 1'b1;
            tick(1);
            wait_stop_instr_i = 1'b0;
            tick(6);
            check(strobe_n_o, !(i == 3));
            access(1'b1, 1'b0, 24'h000200, 16'($urandom));
        end
        $display("standby test done");
        reset_to(1'b1);
        check(eval_mode_o, 1'b1);
        strobe_clock_out_disable_i = 1'b1;
        for (i = 0; i < 32; i++) begin
            dbg = 8'($urandom);
            {flag_m_i, flag_x_i, using_x_i, queue_clear_i} = dbg[7:4];
            {data_buf_access_i, opcode_fetch_i, queue_read_i, debug_ctrl_in_i} = dbg[3:0];
            tick(3);
            check(dbg_seen, exp_dbg(dbg));
        end
        $display("debug test done");
        {byte_wide_i, wait_bit_i} = 2'h2;
        access(1'b1, 1'b0, `EBHR_P4_DATA_ADDR, 16'h1234);
        check({b16, lat < 8 * `EBHR_PHI_HALF}, 2'h3);
        access(1'b1, 1'b0, `EBHR_P4_DIR_ADDR, 16'h4321);
        check(b16, 1'b1);
        access(1'b1, 1'b0, 24'h001000, 16'h4321);
        check(b16, 1'b0);
        $display("port test done");
        stop_test;
    end
endmodule
bind ebhr_bus_ctrl ebhr_bus_ctrl_assertions #(.AW(AW)) i_chk (.*);
`default_nettype wire
